/* File: rtl/fms_field_mode_sequencer.sv */
`timescale 1ns/1ps
`include "fms_map.svh"
// Operation
// [RQ1] A 3-bit cycle length register sets how many slots cycle, 1 to 7.
// [RQ2] Seven 5-bit slot selectors; slots 0-4 in one register, 5-6 in next.
// [RQ3] After a mode update slot zero is used, then advance each field.
// [RQ4] After the programmed slot count, return to slot zero and keep cycling.
// [RQ5] Only a write to the slots five-six register resets the slot counter.
// [RQ6] Host should rewrite all three mode registers within one field.
// [RQ7] By default new mode values apply as soon as the serial write ends.
// [RQ8] Update-control patterns delay mode use to the second field-sync fall.
// [RQ9] By default the substrate clock pulses in every field.
// [RQ10] At most one substrate pulse per line; count from the pulse count register.
// [RQ11] Start polarity and two toggle pixels shape each substrate pulse line.
// [RQ12] Substrate pulses begin in the line after the sensor-gate line.
// [RQ13] Substrate settings are taken into use at the line after gate line.
// [RQ14] Pulse count is 13 bits, 1 to 8191, below the field length.
// [RQ15] Start offset 0 means next line, 2 means two lines later; 1 is illegal.
// [RQ16] Each toggle position is a 13-bit pixel location.
// [RQ17] A 13-bit gate active line register is the substrate reference.
// [RQ18] Outside pulse lines the substrate clock holds its start polarity.
// [RQ19] The slot counter advances on field-sync fall, wrapping at the length.
module fms_field_mode_sequencer (
  input  wire logic        ref_clk,             // Pixel clock, 25 MHz.
  input  wire logic        rst,                 // Asynchronous reset, active high.
  input  wire logic        sck,                 // Serial clock pin.
  input  wire logic        sdata,               // Serial data pin.
  input  wire logic        sl_n,                // Serial load pin, active low.
  input  wire logic        field_sync,          // Field sync pin, falling edge starts a field.
  input  wire logic        line_sync,           // Line sync pin, falling edge starts a line.
  output logic             substrate_clock,     // Substrate clock to the vertical driver.
  output fms_pkg::fms_slot_t active_field_select, // Field timing set now in use.
  output fms_pkg::fms_len_t  active_slot,       // Cycle position now in use.
  output logic             update_pending       // A synchronised mode write waits.
);
  import fms_pkg::*;

  fms_wr_if wr ();

  fms_serial_rx u_rx (
    .ref_clk (ref_clk),
    .rst     (rst),
    .sck     (sck),
    .sdata   (sdata),
    .sl_n    (sl_n),
    .wr      (wr)
  );

  logic [2:0]  vd_sy_reg;
  logic [2:0]  hd_sy_reg;
  logic        vd_fall;
  logic        hd_fall;
  logic [15:0] upd_a_reg;
  logic [15:0] upd_b_reg;
  logic        vd_mode;
  fms_len_t    len_stg_reg;
  logic [24:0] s04_stg_reg;
  logic [9:0]  s56_stg_reg;
  logic        clr_stg_reg;
  fms_len_t    len_live_reg;
  logic [24:0] s04_live_reg;
  logic [9:0]  s56_live_reg;
  logic [1:0]  pend_reg;
  logic        wr_mode;
  logic        apply_now;
  logic        clr_now;
  fms_len_t    eff_len;
  logic [3:0]  slot_inc;
  fms_slot_t   sel_mux;
  logic        sub_pol_w_reg;
  fms_pos_t    tog1_w_reg;
  fms_pos_t    tog2_w_reg;
  fms_pos_t    cnt_w_reg;
  fms_pos_t    off_w_reg;
  fms_pos_t    gate_line_reg;
  logic        pol_act_reg;
  fms_pos_t    tog1_act_reg;
  fms_pos_t    tog2_act_reg;
  fms_pos_t    cnt_act_reg;
  fms_pos_t    off_act_reg;
  fms_pos_t    pix_reg;
  fms_pos_t    line_reg;
  fms_pos_t    line_next;
  logic        sub_load;
  fms_pos_t    cnt_use;
  fms_pos_t    off_use;
  logic [13:0] start_line;
  logic [14:0] stop_line;
  logic        pulse_line_reg;

  // Field and line sync come from pins, so each passes two flops before use.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vd_sy_reg <= 3'h7;
      hd_sy_reg <= 3'h7;
    end else begin
      vd_sy_reg <= {vd_sy_reg[1:0], field_sync};
      hd_sy_reg <= {hd_sy_reg[1:0], line_sync};
    end
  end

  assign vd_fall = vd_sy_reg[2] && !vd_sy_reg[1];
  assign hd_fall = hd_sy_reg[2] && !hd_sy_reg[1];

  // Update-control registers; only the exact pattern pair selects field-synchronised mode.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      upd_a_reg <= 16'h0000;
      upd_b_reg <= 16'h0000;
    end else if (wr.stb && wr.addr == `FMS_ADDR_UPD_CTRL_A) begin
      upd_a_reg <= wr.data[15:0];
    end else if (wr.stb && wr.addr == `FMS_ADDR_UPD_CTRL_B) begin
      upd_b_reg <= wr.data[15:0];
    end
  end

  assign vd_mode = (upd_a_reg == `FMS_UPD_A_SYNC) && (upd_b_reg == `FMS_UPD_B_SYNC); // [RQ8]
  assign wr_mode = wr.stb && (wr.addr == `FMS_ADDR_CYCLE_LEN || wr.addr == `FMS_ADDR_SLOTS_0_4
                              || wr.addr == `FMS_ADDR_SLOTS_5_6);

  // Staging copies always take the write; the live copies follow when the update is due.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      len_stg_reg <= `FMS_RST_CYCLE_LEN;
      s04_stg_reg <= `FMS_RST_SLOTS_0_4;
      s56_stg_reg <= `FMS_RST_SLOTS_5_6;
    end else if (wr.stb && wr.addr == `FMS_ADDR_CYCLE_LEN) begin
      len_stg_reg <= wr.data[2:0]; // [RQ1]
    end else if (wr.stb && wr.addr == `FMS_ADDR_SLOTS_0_4) begin
      s04_stg_reg <= wr.data[24:0]; // [RQ2]
    end else if (wr.stb && wr.addr == `FMS_ADDR_SLOTS_5_6) begin
      s56_stg_reg <= wr.data[9:0]; // [RQ2]
    end
  end

  // A later write restarts the two-edge wait, so a burst of writes lands together.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend_reg    <= 2'h0;
      clr_stg_reg <= 1'b0;
    end else if (wr_mode && vd_mode) begin
      pend_reg <= `FMS_VD_UPDATE_EDGES; // [RQ8]
      if (wr.addr == `FMS_ADDR_SLOTS_5_6) begin
        clr_stg_reg <= 1'b1;
      end
    end else if (vd_fall && pend_reg != 2'h0) begin
      pend_reg <= pend_reg - 2'h1;
      if (pend_reg == 2'h1) begin
        clr_stg_reg <= 1'b0;
      end
    end
  end

  assign apply_now = vd_fall && pend_reg == 2'h1 && !(wr_mode && vd_mode);
  assign clr_now   = (wr.stb && !vd_mode && wr.addr == `FMS_ADDR_SLOTS_5_6) // [RQ5]
                     || (apply_now && clr_stg_reg);

  // Live mode registers: straight from the write by default, else from staging.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      len_live_reg <= `FMS_RST_CYCLE_LEN;
      s04_live_reg <= `FMS_RST_SLOTS_0_4;
      s56_live_reg <= `FMS_RST_SLOTS_5_6;
    end else if (apply_now) begin
      len_live_reg <= len_stg_reg; // [RQ8]
      s04_live_reg <= s04_stg_reg;
      s56_live_reg <= s56_stg_reg;
    end else if (wr.stb && !vd_mode) begin
      if (wr.addr == `FMS_ADDR_CYCLE_LEN) begin
        len_live_reg <= wr.data[2:0]; // [RQ7]
      end else if (wr.addr == `FMS_ADDR_SLOTS_0_4) begin
        s04_live_reg <= wr.data[24:0]; // [RQ7]
      end else if (wr.addr == `FMS_ADDR_SLOTS_5_6) begin
        s56_live_reg <= wr.data[9:0]; // [RQ7]
      end
    end
  end

  // A length of zero is out of range; it behaves as one so the counter never runs away.
  assign eff_len  = (len_live_reg == 3'h0) ? 3'h1 : len_live_reg;
  assign slot_inc = {1'b0, active_slot} + 4'h1;

  // Slot counter: reset wins over a field-sync advance in the same cycle.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      active_slot <= 3'h0;
    end else if (clr_now) begin
      active_slot <= 3'h0; // [RQ3] [RQ5]
    end else if (vd_fall) begin
      if (slot_inc >= {1'b0, eff_len}) begin
        active_slot <= 3'h0; // [RQ4] [RQ19]
      end else begin
        active_slot <= slot_inc[2:0]; // [RQ19]
      end
    end
  end

  // Pick the selector of the current slot.
  always_comb begin
    case (active_slot)
      3'h0:    sel_mux = s04_live_reg[4:0];
      3'h1:    sel_mux = s04_live_reg[9:5];
      3'h2:    sel_mux = s04_live_reg[14:10];
      3'h3:    sel_mux = s04_live_reg[19:15];
      3'h4:    sel_mux = s04_live_reg[24:20];
      3'h5:    sel_mux = s56_live_reg[4:0];
      default: sel_mux = s56_live_reg[9:5];
    endcase
  end

  // Registered outputs for the field select and the pending flag.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      active_field_select <= 5'h00;
      update_pending      <= 1'b0;
    end else begin
      active_field_select <= sel_mux; // [RQ2] [RQ3]
      update_pending      <= (pend_reg != 2'h0);
    end
  end

  // Substrate and gate-line registers, written by software at any time.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sub_pol_w_reg <= `FMS_RST_SUB_POL;
      tog1_w_reg    <= `FMS_RST_SUB_TOG1;
      tog2_w_reg    <= `FMS_RST_SUB_TOG2;
      cnt_w_reg     <= `FMS_RST_SUB_COUNT;
      off_w_reg     <= `FMS_RST_SUB_START;
      gate_line_reg <= `FMS_RST_GATE_LINE;
    end else if (wr.stb) begin
      if (wr.addr == `FMS_ADDR_SUB_POL) begin
        sub_pol_w_reg <= wr.data[0];
      end else if (wr.addr == `FMS_ADDR_SUB_TOG1) begin
        tog1_w_reg <= wr.data[12:0]; // [RQ16]
      end else if (wr.addr == `FMS_ADDR_SUB_TOG2) begin
        tog2_w_reg <= wr.data[12:0]; // [RQ16]
      end else if (wr.addr == `FMS_ADDR_SUB_COUNT) begin
        cnt_w_reg <= wr.data[12:0]; // [RQ14]
      end else if (wr.addr == `FMS_ADDR_SUB_START) begin
        off_w_reg <= wr.data[12:0]; // [RQ15]
      end else if (wr.addr == `FMS_ADDR_GATE_LINE) begin
        gate_line_reg <= wr.data[12:0]; // [RQ17]
      end
    end
  end

  // Pixel and line position; both saturate so a missing sync cannot wrap them.
  assign line_next = vd_fall ? 13'h0000 : ((line_reg == 13'h1fff) ? line_reg : line_reg + 13'h1);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pix_reg  <= 13'h0000;
      line_reg <= 13'h0000;
    end else begin
      if (hd_fall) begin
        pix_reg  <= 13'h0000;
        line_reg <= line_next;
      end else begin
        if (pix_reg != 13'h1fff) begin
          pix_reg <= pix_reg + 13'h1;
        end
        if (vd_fall) begin
          line_reg <= 13'h0000;
        end
      end
    end
  end

  // New settings take effect at the start of the line after the gate line.
  assign sub_load = hd_fall && ({1'b0, line_next} == {1'b0, gate_line_reg} + 14'h1); // [RQ13]
  assign cnt_use  = sub_load ? cnt_w_reg : cnt_act_reg;
  assign off_use  = sub_load ? off_w_reg : off_act_reg;
  // Offset zero means the next line; any other value counts lines after the gate line.
  assign start_line = {1'b0, gate_line_reg}
                      + ((off_use == 13'h0000) ? 14'h0001 : {1'b0, off_use}); // [RQ12] [RQ15]
  assign stop_line  = {1'b0, start_line} + {2'b00, cnt_use}; // [RQ10]

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pol_act_reg  <= `FMS_RST_SUB_POL;
      tog1_act_reg <= `FMS_RST_SUB_TOG1;
      tog2_act_reg <= `FMS_RST_SUB_TOG2;
      cnt_act_reg  <= `FMS_RST_SUB_COUNT;
      off_act_reg  <= `FMS_RST_SUB_START;
    end else if (sub_load) begin
      pol_act_reg  <= sub_pol_w_reg; // [RQ13]
      tog1_act_reg <= tog1_w_reg;
      tog2_act_reg <= tog2_w_reg;
      cnt_act_reg  <= cnt_w_reg;
      off_act_reg  <= off_w_reg;
    end
  end

  // One pulse line per line, in every field, for the programmed number of lines.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pulse_line_reg <= 1'b0;
    end else if (hd_fall) begin
      pulse_line_reg <= ({1'b0, line_next} >= start_line)
                        && ({2'b00, line_next} < stop_line); // [RQ9] [RQ10] [RQ12]
    end
  end

  // Rest level outside pulse lines; a load line opens at the new polarity at once.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      substrate_clock <= `FMS_RST_SUB_POL;
    end else if (!pulse_line_reg || hd_fall) begin
      substrate_clock <= sub_load ? sub_pol_w_reg : pol_act_reg; // [RQ13] [RQ18]
    end else if (pix_reg == tog1_act_reg) begin
      substrate_clock <= !pol_act_reg; // [RQ11]
    end else if (pix_reg == tog2_act_reg) begin
      substrate_clock <= pol_act_reg; // [RQ11]
    end
  end

  AST_SLOT_ADVANCE: assert property (@(posedge ref_clk) disable iff (rst) // [RQ19]
    (vd_fall && !clr_now && slot_inc < {1'b0, eff_len}) |=> active_slot == $past(slot_inc[2:0]))
    else $error("slot did not advance on field sync");
  AST_SLOT_WRAP: assert property (@(posedge ref_clk) disable iff (rst) // [RQ4]
    (vd_fall && slot_inc >= {1'b0, eff_len}) |=> active_slot == 3'h0)
    else $error("slot did not wrap at cycle length");
  AST_SLOT_CLEAR: assert property (@(posedge ref_clk) disable iff (rst) // [RQ5]
    (wr.stb && !vd_mode && wr.addr != `FMS_ADDR_SLOTS_5_6 && !vd_fall)
    |=> active_slot == $past(active_slot))
    else $error("slot moved on a write to another register");
  AST_FIRST_SLOT: assert property (@(posedge ref_clk) disable iff (rst) // [RQ3]
    (clr_now && !wr_mode) ##1 !wr.stb |=> active_field_select == s04_live_reg[4:0])
    else $error("slot zero selector not used after update");
  AST_IMMEDIATE: assert property (@(posedge ref_clk) disable iff (rst) // [RQ7]
    (wr.stb && !vd_mode && !apply_now && wr.addr == `FMS_ADDR_CYCLE_LEN)
    |=> len_live_reg == $past(wr.data[2:0]))
    else $error("cycle length not applied at once");
  AST_VD_DELAY: assert property (@(posedge ref_clk) disable iff (rst) // [RQ8]
    (wr_mode && vd_mode && !apply_now) |=> len_live_reg == $past(len_live_reg)
    && pend_reg == 2'h2)
    else $error("synchronised mode write applied too early");
  AST_LOAD: assert property (@(posedge ref_clk) disable iff (rst) // [RQ13]
    sub_load |=> cnt_act_reg == $past(cnt_w_reg) && tog1_act_reg == $past(tog1_w_reg))
    else $error("substrate settings not loaded after gate line");
  AST_REST_LEVEL: assert property (@(posedge ref_clk) disable iff (rst) // [RQ18]
    (!pulse_line_reg && !sub_load) |=> substrate_clock == pol_act_reg)
    else $error("substrate clock left rest level outside pulse lines");
  AST_TOGGLE: assert property (@(posedge ref_clk) disable iff (rst) // [RQ11]
    (pulse_line_reg && !hd_fall && pix_reg == tog1_act_reg) |=> substrate_clock != pol_act_reg)
    else $error("substrate clock missed first toggle");
endmodule

/* File: rtl/fms_map.svh */
`ifndef FMS_MAP_SVH
`define FMS_MAP_SVH

// Mode register offsets on the serial port.
`define FMS_ADDR_CYCLE_LEN      8'h2a
`define FMS_ADDR_SLOTS_0_4      8'h2b
`define FMS_ADDR_SLOTS_5_6      8'h2c
// Update-control registers and the patterns that make mode writes field-synchronised.
`define FMS_ADDR_UPD_CTRL_A     8'hb4
`define FMS_ADDR_UPD_CTRL_B     8'hb5
`define FMS_UPD_A_SYNC          16'h03ff
`define FMS_UPD_B_SYNC          16'hfc00
// Substrate clock registers.
`define FMS_ADDR_SUB_COUNT      8'h75
`define FMS_ADDR_SUB_POL        8'h76
`define FMS_ADDR_SUB_TOG1       8'h77
`define FMS_ADDR_SUB_TOG2       8'h78
`define FMS_ADDR_SUB_START      8'h79
`define FMS_ADDR_GATE_LINE      8'h7a

// Serial word layout: address then data, both shifted in least significant bit first.
`define FMS_SER_ADDR_W          8
`define FMS_SER_DATA_W          28
`define FMS_SER_BITS            6'd36

// Field positions and widths.
`define FMS_SLOT_W              5
`define FMS_LEN_W               3
`define FMS_POS_W               13

// Reset values.
`define FMS_RST_CYCLE_LEN       3'h1
`define FMS_RST_SLOTS_0_4       25'h0000000
`define FMS_RST_SLOTS_5_6       10'h000
`define FMS_RST_SUB_COUNT       13'h0001
`define FMS_RST_SUB_POL         1'h0
`define FMS_RST_SUB_TOG1        13'h0000
`define FMS_RST_SUB_TOG2        13'h0000
`define FMS_RST_SUB_START       13'h0000
`define FMS_RST_GATE_LINE       13'h0000

// Field-sync falling edges between a synchronised mode write and its use.
`define FMS_VD_UPDATE_EDGES     2'h2

`endif

/* File: rtl/fms_pkg.sv */
package fms_pkg;
  typedef enum logic {FMS_RX_IDLE, FMS_RX_SHIFT} fms_rx_state_e;
  typedef logic [4:0]  fms_slot_t;
  typedef logic [12:0] fms_pos_t;
  typedef logic [2:0]  fms_len_t;
endpackage

/* File: rtl/fms_wr_if.sv */
`timescale 1ns/1ps
// Carries one completed register write from the serial receiver to the sequencer.
interface fms_wr_if;
  logic [7:0]  addr;
  logic [27:0] data;
  logic        stb;
  modport src (output addr, output data, output stb);
  modport snk (input addr, input data, input stb);
endinterface

/* File: rtl/fms_serial_rx.sv */
`timescale 1ns/1ps
`include "fms_map.svh"
// Three-wire write-only serial receiver; a word is taken when the load pin rises.
module fms_serial_rx (
  input  wire logic ref_clk,    // Pixel clock.
  input  wire logic rst,        // Asynchronous reset, active high.
  input  wire logic sck,        // Serial clock pin.
  input  wire logic sdata,      // Serial data pin.
  input  wire logic sl_n,       // Serial load pin, active low.
  fms_wr_if.src     wr          // Completed write.
);
  import fms_pkg::*;

  logic [2:0]  sck_sy_reg;
  logic [1:0]  sda_sy_reg;
  logic [2:0]  sl_sy_reg;
  logic [35:0] shift_reg;
  logic [5:0]  nbits_reg;
  fms_rx_state_e state_reg;

  // Two flops before any logic looks at a pin; the third stage only serves edge detection.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sck_sy_reg <= 3'h0;
      sda_sy_reg <= 2'h0;
      sl_sy_reg  <= 3'h7;
    end else begin
      sck_sy_reg <= {sck_sy_reg[1:0], sck};
      sda_sy_reg <= {sda_sy_reg[0], sdata};
      sl_sy_reg  <= {sl_sy_reg[1:0], sl_n};
    end
  end

  // Bits enter at the top so that the first bit ends in bit 0 after a full word.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= FMS_RX_IDLE;
      shift_reg <= 36'h0;
      nbits_reg <= 6'h0;
      wr.stb    <= 1'b0;
      wr.addr   <= 8'h00;
      wr.data   <= 28'h0000000;
    end else begin
      wr.stb <= 1'b0;
      case (state_reg)
        FMS_RX_IDLE: begin
          nbits_reg <= 6'h0;
          if (!sl_sy_reg[1]) begin
            state_reg <= FMS_RX_SHIFT;
          end
        end
        FMS_RX_SHIFT: begin
          if (sl_sy_reg[1]) begin
            // A short or long frame is dropped rather than writing a garbled register.
            state_reg <= FMS_RX_IDLE;
            if (nbits_reg == `FMS_SER_BITS) begin
              wr.stb  <= 1'b1;
              wr.addr <= shift_reg[7:0];
              wr.data <= shift_reg[35:8];
            end
          end else if (sck_sy_reg[1] && !sck_sy_reg[2]) begin
            shift_reg <= {sda_sy_reg[1], shift_reg[35:1]};
            if (nbits_reg != 6'h3f) begin
              nbits_reg <= nbits_reg + 6'h1;
            end
          end
        end
        default: state_reg <= FMS_RX_IDLE;
      endcase
    end
  end

  AST_ONE_CYCLE_STB: assert property (@(posedge ref_clk) disable iff (rst)
    wr.stb |=> !wr.stb) else $error("write strobe lasted more than one cycle");
endmodule

/* File: bench/fms_vdrv_model.sv */
`timescale 1ns/1ps
// Vertical driver input stage: counts and measures substrate pulses in each field.
module fms_vdrv_model (
  input  wire logic        ref_clk,         // Pixel clock.
  input  wire logic        rst,             // Reset, active high.
  input  wire logic        field_sync,      // Field sync pin.
  input  wire logic        line_sync,       // Line sync pin.
  input  wire logic        substrate_clock, // Substrate clock from the block.
  input  wire logic        idle_pol,        // Resting level expected between pulses.
  output logic [12:0]      pulse_cnt,       // Pulses seen in this field.
  output logic [12:0]      first_line,      // Line of the first pulse in this field.
  output logic [12:0]      width            // Length of the last pulse in clocks.
);
  logic        fs_q;
  logic        ls_q;
  logic        sc_q;
  logic [12:0] line_no;
  logic [12:0] run;

  // Pins are sampled on the pixel clock; the sync pulses last several clocks, so none is lost.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {fs_q, ls_q, sc_q} <= 3'h6;
      {line_no, run, pulse_cnt, first_line, width} <= '0;
    end else begin
      fs_q <= field_sync;
      ls_q <= line_sync;
      sc_q <= substrate_clock;
      if (fs_q && !field_sync) begin
        line_no   <= 13'h0000;
        pulse_cnt <= 13'h0000;
      end else if (ls_q && !line_sync) begin
        line_no <= line_no + 13'h0001;
      end
      if (substrate_clock != idle_pol) begin
        run <= run + 13'h0001;
        if (sc_q == idle_pol) begin
          pulse_cnt <= pulse_cnt + 13'h0001;
          if (pulse_cnt == 13'h0000) begin
            first_line <= line_no;
          end
        end
      end else if (sc_q != idle_pol) begin
        width <= run;
        run   <= 13'h0000;
      end
    end
  end
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps
`include "fms_map.svh"
module tb;
  import fms_pkg::*;
  logic        ref_clk, rst, sck, sdata, sl_n, field_sync, line_sync, pol;
  logic        substrate_clock, update_pending;
  fms_slot_t   active_field_select;
  fms_len_t    active_slot;
  logic [12:0] pulse_cnt, first_line, width;
  logic [27:0] d04, d56, e04, e56;
  fms_slot_t   s [7];
  fms_slot_t   n [7];
  int          errors, n_checks, cyc;

  fms_field_mode_sequencer u_dut (.ref_clk(ref_clk), .rst(rst), .sck(sck), .sdata(sdata),
    .sl_n(sl_n), .field_sync(field_sync), .line_sync(line_sync),
    .substrate_clock(substrate_clock), .active_field_select(active_field_select),
    .active_slot(active_slot), .update_pending(update_pending));

  fms_vdrv_model u_vdrv (.ref_clk(ref_clk), .rst(rst), .field_sync(field_sync),
    .line_sync(line_sync), .substrate_clock(substrate_clock), .idle_pol(pol),
    .pulse_cnt(pulse_cnt), .first_line(first_line), .width(width));

  // Free-running pixel clock.
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // A hung handshake must not stall the run forever.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end

  task automatic clk(input int k);
    repeat (k) @(negedge ref_clk);
  endtask

  // One serial frame: address then data, least significant bit first.
  task automatic wr(input logic [7:0] a, input logic [27:0] v);
    logic [35:0] w;
    w = {v, a};
    sl_n = 1'b0;
    for (int i = 0; i < 36; i++) begin
      sdata = w[i];
      clk(4);
      sck = 1'b1;
      clk(4);
      sck = 1'b0;
    end
    clk(4);
    sl_n = 1'b1;
    clk(12);
  endtask

  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cs(input fms_len_t k, input fms_slot_t v);
    chk("active_slot", 13'(k), 13'(active_slot));
    chk("active_field_select", 13'(v), 13'(active_field_select));
  endtask

  task automatic fsync();
    field_sync = 1'b0;
    clk(4);
    field_sync = 1'b1;
    clk(8);
  endtask

  // A field of nl lines, 34 clocks each, long enough for toggles at pixels 5 and 9.
  task automatic field(input int nl);
    fsync();
    repeat (nl) begin
      line_sync = 1'b0;
      clk(4);
      line_sync = 1'b1;
      clk(30);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence; field-slot tables are built so every slot carries a distinct selector.
  initial begin
    {rst, sck, sdata, sl_n, field_sync, line_sync, pol} = 7'h4e;
    {d04, d56, e04, e56} = '0;
    for (int i = 0; i < 7; i++) begin
      s[i] = 5'h11 + 5'(i);
      n[i] = 5'h03 + 5'(i);
    end
    for (int i = 0; i < 5; i++) begin
      d04[5*i +: 5] = s[i];
      e04[5*i +: 5] = n[i];
    end
    d56[9:0] = {s[6], s[5]};
    e56[9:0] = {n[6], n[5]};
    clk(10);
    rst = 1'b0;
    clk(2);
    cs(3'h0, 5'h00);
    chk("substrate_clock", 13'h0000, 13'(substrate_clock));
    chk("update_pending", 13'h0000, 13'(update_pending));
    $display("test reset done");
    wr(`FMS_ADDR_CYCLE_LEN, 28'h3);
    wr(`FMS_ADDR_SLOTS_0_4, d04);
    wr(`FMS_ADDR_SLOTS_5_6, d56);
    cs(3'h0, s[0]);
    for (int i = 1; i <= 4; i++) begin
      fsync();
      cs(3'(i % 3), s[i % 3]);
    end
    $display("test three slot cycle done");
    wr(`FMS_ADDR_CYCLE_LEN, 28'h7);
    cs(3'h1, s[1]);
    wr(`FMS_ADDR_SLOTS_0_4, d04);
    wr(8'h55, 28'h0);
    cs(3'h1, s[1]);
    wr(`FMS_ADDR_SLOTS_5_6, d56);
    cs(3'h0, s[0]);
    for (int i = 1; i <= 7; i++) begin
      fsync();
      cs(3'(i % 7), s[i % 7]);
    end
    $display("test seven slot cycle done");
    wr(`FMS_ADDR_UPD_CTRL_A, 28'(`FMS_UPD_A_SYNC));
    wr(`FMS_ADDR_UPD_CTRL_B, 28'(`FMS_UPD_B_SYNC));
    wr(`FMS_ADDR_CYCLE_LEN, 28'h2);
    wr(`FMS_ADDR_SLOTS_0_4, e04);
    wr(`FMS_ADDR_SLOTS_5_6, e56);
    cs(3'h0, s[0]);
    chk("update_pending", 13'h0001, 13'(update_pending));
    fsync();
    chk("update_pending", 13'h0001, 13'(update_pending));
    fsync();
    chk("update_pending", 13'h0000, 13'(update_pending));
    cs(3'h0, n[0]);
    fsync();
    cs(3'h1, n[1]);
    $display("test field synchronised update done");
    wr(`FMS_ADDR_UPD_CTRL_A, 28'h0);
    wr(`FMS_ADDR_CYCLE_LEN, 28'h0);
    cs(3'h1, n[1]);
    repeat (2) begin
      fsync();
      cs(3'h0, n[0]);
    end
    $display("test zero cycle length done");
    pol = 1'b1;
    wr(`FMS_ADDR_SUB_COUNT, 28'h2);
    wr(`FMS_ADDR_SUB_POL, 28'h1);
    wr(`FMS_ADDR_SUB_TOG1, 28'h5);
    wr(`FMS_ADDR_SUB_TOG2, 28'h9);
    wr(`FMS_ADDR_SUB_START, 28'h0);
    wr(`FMS_ADDR_GATE_LINE, 28'h2);
    field(8);
    chk("pulse count", 13'h0002, pulse_cnt);
    field(8);
    chk("pulse count", 13'h0002, pulse_cnt);
    chk("first pulse line", 13'h0003, first_line);
    chk("pulse width", 13'h0004, width);
    chk("substrate idle", 13'h0001, 13'(substrate_clock));
    $display("test substrate default start done");
    wr(`FMS_ADDR_SUB_START, 28'h2);
    wr(`FMS_ADDR_SUB_COUNT, 28'h3);
    field(8);
    repeat (2) begin
      field(8);
      chk("pulse count", 13'h0003, pulse_cnt);
      chk("first pulse line", 13'h0004, first_line);
      chk("substrate idle", 13'h0001, 13'(substrate_clock));
    end
    $display("test substrate offset two done");
    finish_test();
  end
endmodule
